// file: verilog/ssw_defines.vh
// Offsets, field positions, reset values and timing for the supply and stop-watchdog supervisor
`ifndef SSW_DEFINES_VH
`define SSW_DEFINES_VH

`define SSW_CLK_PERIOD_NS   5
// Timing figures in ns
`define SSW_RD1_TIME_NS     10000000
`define SSW_UV_FILT_NS      4000
`define SSW_OV_FILT_NS      4000
`define SSW_CCP_TIME_NS     1000
// Least times round up to whole cycles
`define SSW_UV_FILT_CYC     ((`SSW_UV_FILT_NS + `SSW_CLK_PERIOD_NS - 1) / `SSW_CLK_PERIOD_NS)
`define SSW_OV_FILT_CYC     ((`SSW_OV_FILT_NS + `SSW_CLK_PERIOD_NS - 1) / `SSW_CLK_PERIOD_NS)
`define SSW_CCP_CYC         ((`SSW_CCP_TIME_NS + `SSW_CLK_PERIOD_NS - 1) / `SSW_CLK_PERIOD_NS)
`define SSW_RD1_CYC         ((`SSW_RD1_TIME_NS + `SSW_CLK_PERIOD_NS - 1) / `SSW_CLK_PERIOD_NS)

// Register byte offsets
`define SSW_HARDWARE_CONTROL_REG_ADDR    8'h00
`define SSW_WATCHDOG_CONTROL_REG_ADDR    8'h04
`define SSW_SUPPLY_STATUS_REG_ADDR   8'h08
`define SSW_DEV_STAT_ADDR   8'h0c

// hardware_control_reg fields
`define SSW_HW_ARM_BIT      0
`define SSW_HW_WAKE_BIT     1
`define SSW_HW_CHARGE_PUMP_ENABLE_BIT     2
`define SSW_HW_AREC_BIT     3
`define SSW_HW_HBM_LSB      4
`define SSW_HW_HBM_MSB      11
`define SSW_HARDWARE_CONTROL_REG_RST     12'h002

// watchdog_control_reg fields
`define SSW_WD_CONF_BIT     0

// supply_status_reg fields
`define SSW_ST_LS_UV        0
`define SSW_ST_LS_OV        1
`define SSW_ST_MS_UV        2
`define SSW_ST_MS_OV        3
`define SSW_ST_HIGHSIDE_SUPPLY_UNDERVOLT_FLAG        4
`define SSW_ST_HIGHSIDE_SUPPLY_OVERVOLT_FLAG        5

// device status fields
`define SSW_DS_POR_BIT      0
`define SSW_DS_WDOFF_BIT    1

// Device modes, supplied by the mode controller
`define SSW_MODE_INIT       2'h0
`define SSW_MODE_RESTART    2'h1
`define SSW_MODE_NORMAL     2'h2
`define SSW_MODE_STOP       2'h3

`endif

// file: verilog/ssw_filter.v
// Two-flop synchroniser followed by a persistence filter counter
`timescale 1ns/1ps
module ssw_filter #(
  parameter CYCLES = 1
) (
  // Clock and reset
  input  wire ref_clk_i,
  input  wire reset_i,
  // Raw comparator and gating
  input  wire raw_i,
  input  wire active_i,
  // Filtered condition
  output reg  filt_o
);

  reg        sync_a;
  reg        sync_b;
  reg [11:0] count;

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      count  <= 12'h000;
      filt_o <= 1'b0;
    end else begin
      sync_a <= raw_i;
      sync_b <= sync_a;
      // R25: consecutive persistence
      if (!(sync_b && active_i)) begin
        count  <= 12'h000;
        filt_o <= 1'b0;
      end else if (count >= CYCLES[11:0] - 12'h001) begin
        filt_o <= 1'b1;
      end else begin
        count <= count + 12'h001;
      end
    end
  end

endmodule // ssw_filter

// file: verilog/ssw_supervisor.v
// Stop-mode watchdog gating, power-on reset hold-off and supply monitors
`timescale 1ns/1ps
`include "ssw_defines.vh"

// Function
// R1: disable watchdog only from normal mode
// R2: host writes both bits in order
// R3: sequence error clears confirm bit
// R4: trigger or normal return restarts watchdog
// R5: restart clears arm; arm needs confirm
// R6: bus wake restarts disabled watchdog
// R7: wake-start bit changes only in normal
// R8: bus wake interrupts, pulls receive low
// R9: host re-disables via normal mode
// R10: power-on flags and loads defaults
// R11: reset output held until regulator delay
// R12: logic supply loss resets internally
// R13: logic undervoltage suspends diag, latches flag
// R14: stop mode undervoltage only on load
// R15: logic overvoltage discharges, stops pump, latches
// R16: pump disabled keeps pump, bridge off
// R17: overvoltage recovery per auto-recover bit
// R18: motor undervoltage same shutdown sequence
// R19: motor undervoltage recovery holds bridge
// R20: motor overvoltage also when pump on
// R21: pump restart needs enable, no pump UV; pump UV holds it only with motor OV flag set and auto-recover off
// R22: high-side undervoltage sets own flag
// R23: high-side overvoltage sets own flag
// R24: long open window on watchdog start
// R25: comparators filtered for full time
module ssw_supervisor #(
  parameter RD1_CYCLES = `SSW_RD1_CYC
) (
  // Clock and reset
  input  wire        ref_clk_i,
  input  wire        reset_i,
  // Register port
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  // Device mode
  input  wire [1:0]  mode_i,
  // Analog comparators, asynchronous
  input  wire        logic_supply_por_low_i,
  input  wire        main_reg_above_rt_i,
  input  wire        logic_supply_uv_i,
  input  wire        logic_supply_ov_i,
  input  wire        motor_supply_uv_i,
  input  wire        motor_supply_ov_i,
  input  wire        highside_supply_uv_i,
  input  wire        highside_supply_ov_i,
  input  wire        reg_peak_current_i,
  input  wire        reg_prewarn_i,
  input  wire        pump_above_uv_i,
  input  wire        pump_undervolt_flag_i,
  input  wire        bus_wake_i,
  // Watchdog and wake outputs
  output reg         wd_enabled_o,
  output reg         wd_long_window_o,
  output reg         wake_irq_o,
  output reg         can_receive_output_o,
  // Reset and regulator diagnosis
  output reg         reset_output_low_o,
  output reg         reg_short_diag_en_o,
  output reg         init_restart_o,
  // Bridge and pump control
  output reg  [3:0]  gate_discharge_o,
  output reg         charge_pump_on_o,
  output reg         passive_discharge_o,
  output reg         bridge_enable_o
);

  localparam ST_RUN  = 2'h0;
  localparam ST_DISC = 2'h1;
  localparam ST_OFF  = 2'h2;

  wire        por_low;
  wire        rt_ok;
  wire        wake_s;
  wire        ls_uv_f;
  wire        ls_ov_f;
  wire        ms_uv_f;
  wire        ms_ov_f;
  wire        highside_supply_undervolt_flag_f;
  wire        highside_supply_overvolt_flag_f;
  wire        rst;

  reg  [11:0] hardware_control_reg;
  reg         confirm;
  reg  [5:0]  sup_flags;
  reg         por_flag;
  reg  [1:0]  mode_q;
  reg         wake_q;
  reg  [21:0] rd1_cnt;
  reg  [1:0]  state;
  reg  [7:0]  ccp_cnt;

  wire        arm       = hardware_control_reg[`SSW_HW_ARM_BIT];
  wire        wake_en   = hardware_control_reg[`SSW_HW_WAKE_BIT];
  wire        cp_en     = hardware_control_reg[`SSW_HW_CHARGE_PUMP_ENABLE_BIT];
  wire        auto_rec  = hardware_control_reg[`SSW_HW_AREC_BIT];
  wire [7:0]  hb_mode   = hardware_control_reg[`SSW_HW_HBM_MSB:`SSW_HW_HBM_LSB];
  wire        is_normal = (mode_i == `SSW_MODE_NORMAL);
  wire        is_stop   = (mode_i == `SSW_MODE_STOP);
  wire        run_modes = !is_stop;
  wire        wr_hw     = wr_i && (addr_i == `SSW_HARDWARE_CONTROL_REG_ADDR);
  wire        wr_wd     = wr_i && (addr_i == `SSW_WATCHDOG_CONTROL_REG_ADDR);
  wire        wr_sup    = wr_i && (addr_i == `SSW_SUPPLY_STATUS_REG_ADDR);
  wire        wr_dev    = wr_i && (addr_i == `SSW_DEV_STAT_ADDR);
  wire        wd_off    = arm && confirm;
  wire        wake_rise = wake_s && !wake_q;

  // R4: watchdog trigger in stop, or stop to normal
  wire        trig_stop  = wr_wd && is_stop;
  wire        leave_stop = (mode_q == `SSW_MODE_STOP) && is_normal;
  // R6: wake start only while watchdog is disabled
  wire        wake_start = wake_rise && is_stop && wd_off && wake_en;
  wire        wd_clear   = trig_stop || leave_stop || wake_start;

  // R14: stop mode keeps logic undervoltage only under load
  wire        ls_uv_act = run_modes || reg_peak_current_i || reg_prewarn_i;
  // R20: motor overvoltage also watched while pump is enabled
  wire        ms_ov_act = run_modes || cp_en;
  wire        fault_now = ls_ov_f || ms_uv_f || ms_ov_f;

  integer i;
  reg [3:0] next_disc;

  // R12: losing the logic supply acts as an internal reset
  ssw_filter #(.CYCLES(1)) u_por (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .raw_i     (logic_supply_por_low_i),
    .active_i  (1'b1),
    .filt_o    (por_low)
  );

  assign rst = reset_i || por_low;

  ssw_filter #(.CYCLES(1)) u_rt (
    .ref_clk_i (ref_clk_i),
    .reset_i   (rst),
    .raw_i     (main_reg_above_rt_i),
    .active_i  (1'b1),
    .filt_o    (rt_ok)
  );

  ssw_filter #(.CYCLES(1)) u_wake (
    .ref_clk_i (ref_clk_i),
    .reset_i   (rst),
    .raw_i     (bus_wake_i),
    .active_i  (1'b1),
    .filt_o    (wake_s)
  );

  ssw_filter #(.CYCLES(`SSW_UV_FILT_CYC)) u_ls_uv (
    .ref_clk_i (ref_clk_i),
    .reset_i   (rst),
    .raw_i     (logic_supply_uv_i),
    .active_i  (ls_uv_act),
    .filt_o    (ls_uv_f)
  );

  ssw_filter #(.CYCLES(`SSW_OV_FILT_CYC)) u_ls_ov (
    .ref_clk_i (ref_clk_i),
    .reset_i   (rst),
    .raw_i     (logic_supply_ov_i),
    .active_i  (run_modes),
    .filt_o    (ls_ov_f)
  );

  ssw_filter #(.CYCLES(`SSW_UV_FILT_CYC)) u_ms_uv (
    .ref_clk_i (ref_clk_i),
    .reset_i   (rst),
    .raw_i     (motor_supply_uv_i),
    .active_i  (run_modes),
    .filt_o    (ms_uv_f)
  );

  ssw_filter #(.CYCLES(`SSW_OV_FILT_CYC)) u_ms_ov (
    .ref_clk_i (ref_clk_i),
    .reset_i   (rst),
    .raw_i     (motor_supply_ov_i),
    .active_i  (ms_ov_act),
    .filt_o    (ms_ov_f)
  );

  // High-side comparators have no filter time, one-cycle persistence
  ssw_filter #(.CYCLES(1)) u_highside_supply_undervolt_flag (
    .ref_clk_i (ref_clk_i),
    .reset_i   (rst),
    .raw_i     (highside_supply_uv_i),
    .active_i  (1'b1),
    .filt_o    (highside_supply_undervolt_flag_f)
  );

  ssw_filter #(.CYCLES(1)) u_highside_supply_overvolt_flag (
    .ref_clk_i (ref_clk_i),
    .reset_i   (rst),
    .raw_i     (highside_supply_ov_i),
    .active_i  (1'b1),
    .filt_o    (highside_supply_overvolt_flag_f)
  );

  // Half-bridges in mode 01 or 10 get active discharge
  always @* begin
    next_disc = 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
      // R15: only driven bridge modes
      next_disc[i] = hb_mode[2*i] ^ hb_mode[2*i+1];
    end
  end

  // Control registers and the disable sequence
  always @(posedge ref_clk_i) begin
    if (rst) begin
      // R10: every register back to its default
      hardware_control_reg <= `SSW_HARDWARE_CONTROL_REG_RST;
      confirm <= 1'b0;
      mode_q  <= `SSW_MODE_INIT;
      wake_q  <= 1'b0;
    end else begin
      mode_q <= mode_i;
      wake_q <= wake_s;
      if (wd_clear) begin
        // R4: both disable bits dropped on restart
        hardware_control_reg[`SSW_HW_ARM_BIT] <= 1'b0;
        confirm                  <= 1'b0;
      end else if (wr_wd && is_normal) begin
        // R1: sequence accepted in normal mode only
        if (wdata_i[`SSW_WD_CONF_BIT]) begin
          confirm <= 1'b1;
          // R5: starting again drops a stale arm bit
          hardware_control_reg[`SSW_HW_ARM_BIT] <= 1'b0;
        end else begin
          // R3: out-of-order write aborts the sequence
          confirm <= 1'b0;
        end
      end else if (wr_hw && is_normal) begin
        // R5: arm refused until confirm is set
        // R2: confirm must already stand
        hardware_control_reg[`SSW_HW_ARM_BIT] <= wdata_i[`SSW_HW_ARM_BIT] && confirm;
      end
      if (wr_hw) begin
        hardware_control_reg[`SSW_HW_CHARGE_PUMP_ENABLE_BIT] <= wdata_i[`SSW_HW_CHARGE_PUMP_ENABLE_BIT];
        hardware_control_reg[`SSW_HW_AREC_BIT] <= wdata_i[`SSW_HW_AREC_BIT];
        hardware_control_reg[`SSW_HW_HBM_MSB:`SSW_HW_HBM_LSB] <= wdata_i[`SSW_HW_HBM_MSB:`SSW_HW_HBM_LSB];
        // R7: wake-start bit frozen outside normal mode
        if (is_normal) begin
          hardware_control_reg[`SSW_HW_WAKE_BIT] <= wdata_i[`SSW_HW_WAKE_BIT];
        end
      end
    end
  end

  // Watchdog and wake signalling
  always @(posedge ref_clk_i) begin
    if (rst) begin
      wd_enabled_o         <= 1'b1;
      wd_long_window_o     <= 1'b0;
      wake_irq_o           <= 1'b0;
      can_receive_output_o <= 1'b1;
    end else begin
      wd_enabled_o     <= !(wd_off && is_stop);
      // R24: long open window on restart from disabled and on every stop-to-normal exit
      wd_long_window_o <= (wd_clear && wd_off) || leave_stop;
      // R8: wake interrupt and receive line low
      wake_irq_o <= wake_rise && is_stop;
      if (wake_rise && is_stop) begin
        can_receive_output_o <= 1'b0;
      end else if (!is_stop) begin
        can_receive_output_o <= 1'b1;
      end
    end
  end

  // Power-on flag and reset hold-off
  always @(posedge ref_clk_i) begin
    if (rst) begin
      // R10: power-on flag set on supply rise
      por_flag           <= 1'b1;
      rd1_cnt            <= 22'h000000;
      reset_output_low_o <= 1'b0;
      init_restart_o     <= 1'b1;
    end else begin
      init_restart_o <= 1'b0;
      if (wr_dev && wdata_i[`SSW_DS_POR_BIT]) begin
        por_flag <= 1'b0;
      end
      // R11: release after threshold plus delay
      if (!reset_output_low_o && rt_ok) begin
        if (rd1_cnt >= RD1_CYCLES[21:0] - 22'h000001) begin
          reset_output_low_o <= 1'b1;
        end else begin
          rd1_cnt <= rd1_cnt + 22'h000001;
        end
      end
    end
  end

  // Latched supply flags; a new event beats a clear
  always @(posedge ref_clk_i) begin
    if (rst) begin
      sup_flags           <= 6'h00;
      reg_short_diag_en_o <= 1'b1;
    end else begin
      // R13: diagnosis resumes when undervoltage ends
      reg_short_diag_en_o <= !ls_uv_f;
      // R13: cleared only by a status clear
      sup_flags[`SSW_ST_LS_UV] <= ls_uv_f ||
        (sup_flags[`SSW_ST_LS_UV] && !(wr_sup && wdata_i[`SSW_ST_LS_UV]));
      // R15: logic overvoltage flag
      sup_flags[`SSW_ST_LS_OV] <= ls_ov_f ||
        (sup_flags[`SSW_ST_LS_OV] && !(wr_sup && wdata_i[`SSW_ST_LS_OV]));
      // R18: motor undervoltage flag
      sup_flags[`SSW_ST_MS_UV] <= ms_uv_f ||
        (sup_flags[`SSW_ST_MS_UV] && !(wr_sup && wdata_i[`SSW_ST_MS_UV]));
      // R20: motor overvoltage flag
      sup_flags[`SSW_ST_MS_OV] <= ms_ov_f ||
        (sup_flags[`SSW_ST_MS_OV] && !(wr_sup && wdata_i[`SSW_ST_MS_OV]));
      // R22: clear refused while condition stands
      sup_flags[`SSW_ST_HIGHSIDE_SUPPLY_UNDERVOLT_FLAG] <= highside_supply_undervolt_flag_f ||
        (sup_flags[`SSW_ST_HIGHSIDE_SUPPLY_UNDERVOLT_FLAG] && !(wr_sup && wdata_i[`SSW_ST_HIGHSIDE_SUPPLY_UNDERVOLT_FLAG]));
      // R23: same for high-side overvoltage
      sup_flags[`SSW_ST_HIGHSIDE_SUPPLY_OVERVOLT_FLAG] <= highside_supply_overvolt_flag_f ||
        (sup_flags[`SSW_ST_HIGHSIDE_SUPPLY_OVERVOLT_FLAG] && !(wr_sup && wdata_i[`SSW_ST_HIGHSIDE_SUPPLY_OVERVOLT_FLAG]));
    end
  end

  // Shutdown: discharge gates, then pump off, then wait for recovery
  always @(posedge ref_clk_i) begin
    if (rst) begin
      state               <= ST_RUN;
      ccp_cnt             <= 8'h00;
      gate_discharge_o    <= 4'h0;
      charge_pump_on_o    <= 1'b0;
      passive_discharge_o <= 1'b0;
      bridge_enable_o     <= 1'b0;
    end else begin
      case (state)
        ST_RUN: begin
          // R15: fault starts the shutdown order
          // R18: motor undervoltage same order
          if (fault_now) begin
            state            <= ST_DISC;
            ccp_cnt          <= 8'h00;
            gate_discharge_o <= next_disc;
            bridge_enable_o  <= 1'b0;
          end else begin
            // R21: pump held by its own undervoltage only with motor OV flag set and auto-recover off
            // R16: pump disabled keeps pump and bridge off, passive discharge on
            charge_pump_on_o <= cp_en && !(pump_undervolt_flag_i && !auto_rec &&
                                           sup_flags[`SSW_ST_MS_OV]);
            passive_discharge_o <= !cp_en;
            // R17: auto-recover ignores overvoltage flags
            // R19: bridge waits for motor UV flag clear
            bridge_enable_o <= cp_en && pump_above_uv_i && !sup_flags[`SSW_ST_MS_UV] &&
                               (auto_rec || !(sup_flags[`SSW_ST_LS_OV] || sup_flags[`SSW_ST_MS_OV]));
          end
        end
        ST_DISC: begin
          // Discharge lasts the cross-current protect time
          if (ccp_cnt >= `SSW_CCP_CYC - 8'h01) begin
            state               <= ST_OFF;
            gate_discharge_o    <= 4'h0;
            charge_pump_on_o    <= 1'b0;
            passive_discharge_o <= 1'b1;
          end else begin
            ccp_cnt <= ccp_cnt + 8'h01;
          end
        end
        ST_OFF: begin
          // R17: restart once every condition ends
          if (!fault_now) begin
            state <= ST_RUN;
          end
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  // Read data stand one cycle after the strobe
  always @(posedge ref_clk_i) begin
    if (rst) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      if (addr_i == `SSW_HARDWARE_CONTROL_REG_ADDR) begin
        rdata_o <= {20'h00000, hardware_control_reg};
      end else if (addr_i == `SSW_WATCHDOG_CONTROL_REG_ADDR) begin
        rdata_o <= {31'h00000000, confirm};
      end else if (addr_i == `SSW_SUPPLY_STATUS_REG_ADDR) begin
        rdata_o <= {26'h0000000, sup_flags};
      end else if (addr_i == `SSW_DEV_STAT_ADDR) begin
        rdata_o <= {28'h0000000, state, wd_off, por_flag};
      end else begin
        rdata_o <= 32'h00000000;
      end
    end else begin
      rdata_o <= 32'h00000000;
    end
  end

endmodule // ssw_supervisor

// file: testbench/ssw_supervisor_sva.sv
// Concurrent checks on the supervisor ports
`timescale 1ns/1ps
`include "ssw_defines.vh"
module ssw_supervisor_sva #(
  parameter RD1_CYCLES = 20
) (
  // Clock, reset and mode
  input wire       ref_clk_i,
  input wire       reset_i,
  input wire [1:0] mode_i,
  // Watched comparators
  input wire       main_reg_above_rt_i,
  input wire       logic_supply_uv_i,
  // Watched outputs
  input wire       wd_enabled_o,
  input wire       wd_long_window_o,
  input wire       wake_irq_o,
  input wire       can_receive_output_o,
  input wire       reset_output_low_o,
  input wire       reg_short_diag_en_o,
  input wire       init_restart_o,
  input wire [3:0] gate_discharge_o,
  input wire       charge_pump_on_o,
  input wire       passive_discharge_o,
  input wire       bridge_enable_o
);
  localparam int CCP  = 200;
  localparam int FILT = 800;
  // Run lengths of causes; counters avoid long repetitions
  logic [31:0] gc;
  logic [31:0] uc;
  logic [31:0] rc;
  always @(posedge ref_clk_i) begin
    gc <= (reset_i || ~|gate_discharge_o) ? 32'h0 : gc + 32'h1;
    uc <= (reset_i || !logic_supply_uv_i) ? 32'h0 : uc + 32'h1;
    rc <= (reset_i || init_restart_o || !main_reg_above_rt_i) ? 32'h0 : rc + 32'h1;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  a_gate_bridge: assert property (|gate_discharge_o |-> !bridge_enable_o)
    else $error("bridge on during gate discharge");
  a_gate_len: assert property ($fell(|gate_discharge_o) && !init_restart_o |-> gc == CCP)
    else $error("gate discharge length wrong");
  a_gate_pump: assert property ($fell(|gate_discharge_o) && !init_restart_o |->
                                !charge_pump_on_o && passive_discharge_o)
    else $error("pump not stopped after discharge");
  a_rx_stop: assert property ((mode_i != `SSW_MODE_STOP) [*3] |-> can_receive_output_o)
    else $error("receive output low outside stop");
  a_wd_stop: assert property ((mode_i != `SSW_MODE_STOP) [*3] |-> wd_enabled_o)
    else $error("watchdog off outside stop");
  a_long_norm: assert property ($past(mode_i) == `SSW_MODE_STOP && mode_i == `SSW_MODE_NORMAL
                                |-> ##[0:2] wd_long_window_o)
    else $error("no long window on stop exit");
  a_long_pulse: assert property (wd_long_window_o |=> !wd_long_window_o)
    else $error("long window pulse too long");
  a_irq_rx: assert property (wake_irq_o |-> mode_i == `SSW_MODE_STOP ##[0:2] !can_receive_output_o)
    else $error("wake interrupt without receive low");
  a_rst_hold: assert property (init_restart_o |-> !reset_output_low_o)
    else $error("reset output released in internal reset");
  a_rst_delay: assert property ($rose(reset_output_low_o) |-> rc >= RD1_CYCLES)
    else $error("reset output released early");
  a_uv_filter: assert property ($fell(reg_short_diag_en_o) |-> uc >= FILT)
    else $error("undervoltage acted before filter time");

  c_discharge: cover property (|gate_discharge_o);
  c_wake: cover property (wake_irq_o);
  c_long: cover property (wd_long_window_o);
endmodule // ssw_supervisor_sva

bind ssw_supervisor ssw_supervisor_sva #(.RD1_CYCLES(RD1_CYCLES)) u_sva (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .mode_i(mode_i), .main_reg_above_rt_i(main_reg_above_rt_i),
  .logic_supply_uv_i(logic_supply_uv_i), .wd_enabled_o(wd_enabled_o), .wd_long_window_o(wd_long_window_o),
  .wake_irq_o(wake_irq_o), .can_receive_output_o(can_receive_output_o), .reset_output_low_o(reset_output_low_o),
  .reg_short_diag_en_o(reg_short_diag_en_o), .init_restart_o(init_restart_o), .gate_discharge_o(gate_discharge_o),
  .charge_pump_on_o(charge_pump_on_o), .passive_discharge_o(passive_discharge_o), .bridge_enable_o(bridge_enable_o)
);

// file: testbench/ssw_host_model.sv
// Host model: register bus master and watchdog disable sequence
`timescale 1ns/1ps
module ssw_host_model (
  // Clock
  input  wire         ref_clk_i,
  // Register bus
  input  wire  [31:0] rdata_i,
  output logic [7:0]  addr_o,
  output logic [31:0] wdata_o,
  output logic        wr_o,
  output logic        rd_o
);
  initial begin
    addr_o  = 8'h00;
    wdata_o = 32'h0;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end
  // Released lines show the inverse, never a stale copy
  task automatic write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge ref_clk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic read(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge ref_clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    @(posedge ref_clk_i);
    d = rdata_i;
  endtask
  // called in normal mode only, confirm then arm
  task automatic dis(input logic [31:0] hw);
    write(8'h04, 32'h1);
    write(8'h00, hw | 32'h1);
  endtask
endmodule // ssw_host_model

// file: testbench/test_supply_and_stop_wd_supervisor.sv
// Directed bench for the supply and stop-watchdog supervisor
`timescale 1ns/1ps
`include "ssw_defines.vh"
module test_supply_and_stop_wd_supervisor;
  localparam int RD1 = 20;
  logic        ref_clk_i;
  logic        reset_i;
  logic [1:0]  mode;
  logic        por_low;
  logic        ls_uv;
  logic [2:0]  flt;
  logic [1:0]  hs;
  logic        peak;
  logic        pu_flag;
  logic        wake;
  logic        rt_in;
  logic        prew;
  logic        pu_ok;
  wire         lwin;
  wire         irq;
  int          irq_n;
  int          lwin_n;
  wire  [7:0]  addr;
  wire  [31:0] wdata;
  wire         wr;
  wire         rd;
  wire  [31:0] rdata;
  wire  [3:0]  gate;
  wire         wd_en, rxd, rst_out, diag, init_rs, pump, passive, bridge;
  int          error_cnt;
  int          check_count;

  ssw_host_model u_host (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

  ssw_supervisor #(.RD1_CYCLES(RD1)) DUT (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .mode_i(mode), .logic_supply_por_low_i(por_low), .main_reg_above_rt_i(rt_in),
    .logic_supply_uv_i(ls_uv), .logic_supply_ov_i(flt[0]), .motor_supply_uv_i(flt[1]),
    .motor_supply_ov_i(flt[2]), .highside_supply_uv_i(hs[0]), .highside_supply_ov_i(hs[1]),
    .reg_peak_current_i(peak), .reg_prewarn_i(prew), .pump_above_uv_i(pu_ok), .pump_undervolt_flag_i(pu_flag),
    .bus_wake_i(wake), .wd_enabled_o(wd_en), .wd_long_window_o(lwin), .wake_irq_o(irq), .can_receive_output_o(rxd),
    .reset_output_low_o(rst_out), .reg_short_diag_en_o(diag), .init_restart_o(init_rs),
    .gate_discharge_o(gate), .charge_pump_on_o(pump), .passive_discharge_o(passive), .bridge_enable_o(bridge)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  // Pulse outputs last one cycle, so count them
  always @(posedge ref_clk_i) begin
    if (irq === 1'b1) irq_n <= irq_n + 1;
    if (lwin === 1'b1) lwin_n <= lwin_n + 1;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic md(input logic [1:0] m);
    @(posedge ref_clk_i) mode <= m;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    u_host.read(a, d);
    chk(d, exp);
  endtask
  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Fault k: 0 logic overvoltage, 1 motor undervoltage, 2 motor overvoltage
  task automatic fault(input int k, input logic aut, input logic pu);
    u_host.write(8'h00, {20'h0, 8'hc9, aut, 3'b110});
    wt(10);
    #1 chk(bridge, 1'b1);
    @(posedge ref_clk_i) flt[k] <= 1'b1;
    wt(820);
    #1 chk(gate, 4'h3);
    chk(bridge, 1'b0);
    wt(200);
    #1 chk({gate, pump, passive}, 6'h01);
    chk_reg(8'h08, 32'h1 << (k + 1));
    @(posedge ref_clk_i) flt[k] <= 1'b0;
    pu_flag <= pu;
    wt(820);
    #1 chk(pump, !(pu && !aut && k == 2));
    chk(bridge, aut && k != 1);
    @(posedge ref_clk_i) pu_flag <= 1'b0;
    u_host.write(8'h08, 32'h1 << (k + 1));
    wt(10);
    #1 chk(bridge, 1'b1);
  endtask

  initial begin
    #200000;
    error_cnt++;
    report_and_stop;
  end

  initial begin
    reset_i = 1'b1;
    mode = `SSW_MODE_INIT;
    {por_low, ls_uv, flt, hs, peak, pu_flag, wake} = 10'h0;
    {rt_in, prew, pu_ok} = 3'b101;
    irq_n = 0;
    lwin_n = 0;
    error_cnt = 0;
    check_count = 0;
    wt(3);
    reset_i <= 1'b0;
    wt(2);
    #1 chk(rst_out, 1'b0);
    wt(30);
    #1 chk(rst_out, 1'b1);
    chk_reg(8'h0c, 32'h1);
    chk_reg(8'h00, 32'h2);
    chk_reg(8'h10, 32'h0);
    u_host.write(8'h0c, 32'h1);
    chk_reg(8'h0c, 32'h0);
    u_host.write(8'h00, 32'h0);
    chk_reg(8'h00, 32'h2);
    md(`SSW_MODE_NORMAL);
    u_host.write(8'h00, 32'h3);
    chk_reg(8'h00, 32'h2);
    u_host.dis(32'h2);
    chk_reg(8'h0c, 32'h2);
    u_host.write(8'h04, 32'h1);
    chk_reg(8'h00, 32'h2);
    u_host.write(8'h04, 32'h0);
    chk_reg(8'h04, 32'h0);
    u_host.dis(32'h2);
    md(`SSW_MODE_STOP);
    wt(3);
    #1 chk(wd_en, 1'b0);
    @(posedge ref_clk_i) wake <= 1'b1;
    wt(10);
    #1 chk(rxd, 1'b0);
    chk(wd_en, 1'b1);
    chk(irq_n, 32'h1);
    chk(lwin_n, 32'h1);
    chk_reg(8'h04, 32'h0);
    @(posedge ref_clk_i) wake <= 1'b0;
    md(`SSW_MODE_NORMAL);
    wt(3);
    #1 chk(rxd, 1'b1);
    u_host.dis(32'h2);
    md(`SSW_MODE_STOP);
    u_host.write(8'h04, 32'h1);
    wt(3);
    #1 chk(wd_en, 1'b1);
    chk_reg(8'h0c, 32'h0);
    md(`SSW_MODE_NORMAL);
    u_host.dis(32'h2);
    md(`SSW_MODE_STOP);
    md(`SSW_MODE_NORMAL);
    wt(3);
    #1 chk(wd_en, 1'b1);
    chk_reg(8'h00, 32'h2);
    // Wake start off: a bus wake leaves the watchdog off
    u_host.write(8'h00, 32'h0);
    u_host.dis(32'h0);
    md(`SSW_MODE_STOP);
    @(posedge ref_clk_i) wake <= 1'b1;
    wt(10);
    #1 chk(wd_en, 1'b0);
    @(posedge ref_clk_i) wake <= 1'b0;
    md(`SSW_MODE_NORMAL);
    fault(0, 1'b0, 1'b0);
    fault(1, 1'b0, 1'b0);
    fault(2, 1'b0, 1'b1);
    fault(0, 1'b1, 1'b0);
    @(posedge ref_clk_i) ls_uv <= 1'b1;
    wt(820);
    #1 chk(diag, 1'b0);
    @(posedge ref_clk_i) ls_uv <= 1'b0;
    wt(820);
    #1 chk(diag, 1'b1);
    chk_reg(8'h08, 32'h1);
    u_host.write(8'h08, 32'h1);
    chk_reg(8'h08, 32'h0);
    md(`SSW_MODE_STOP);
    @(posedge ref_clk_i) ls_uv <= 1'b1;
    wt(820);
    chk_reg(8'h08, 32'h0);
    @(posedge ref_clk_i) peak <= 1'b1;
    wt(820);
    chk_reg(8'h08, 32'h1);
    @(posedge ref_clk_i) ls_uv <= 1'b0;
    peak <= 1'b0;
    md(`SSW_MODE_NORMAL);
    u_host.write(8'h08, 32'h1);
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk_i) hs[k] <= 1'b1;
      wt(10);
      u_host.write(8'h08, 32'h10 << k);
      chk_reg(8'h08, 32'h10 << k);
      @(posedge ref_clk_i) hs[k] <= 1'b0;
      wt(10);
      u_host.write(8'h08, 32'h10 << k);
      chk_reg(8'h08, 32'h0);
    end
    @(posedge ref_clk_i) por_low <= 1'b1;
    wt(5);
    #1 chk({init_rs, rst_out}, 2'b10);
    @(posedge ref_clk_i) por_low <= 1'b0;
    wt(40);
    #1 chk(init_rs, 1'b0);
    chk_reg(8'h0c, 32'h1);
    chk_reg(8'h00, 32'h2);
    report_and_stop;
  end
endmodule // test_supply_and_stop_wd_supervisor
